// ==== smbc_pkg.sv ====
// package: register map, field layout and types of the supply monitor bank
package smbc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_ALT = 8'h94;
  localparam logic [7:0] OFF_DIG = 8'h98;
  localparam logic [7:0] OFF_IO = 8'h9c;
  localparam logic [7:0] OFF_BKP = 8'ha4;
  localparam logic [7:0] OFF_CFG = 8'hbc;
  localparam logic [7:0] OFF_ANA = 8'hc0;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'hc4;
  localparam logic [7:0] OFF_IRQ_MASK = 8'hc8;
  localparam int NCH = 5;
  localparam int CH_ANA = 0;
  localparam int CH_ALT = 1;
  localparam int CH_DIG = 2;
  localparam int CH_IO = 3;
  localparam int CH_BKP = 4;
  localparam int BIT_EN = 0;
  localparam int BIT_CLIMB = 2;
  localparam int BIT_DROP = 3;
  localparam int BIT_RETREL = 4;
  localparam int FINE_LO = 8;
  localparam int COARSE_LO = 12;
  localparam int BIT_CMPOFF = 31;
  localparam int NORM_LO = 20;
  localparam int BKMODE_LO = 16;
  localparam int SER_LO = 12;
  localparam int VOUT_LO = 8;
  localparam logic [31:0] CH_MASK = 32'h0000ff0d;
  localparam logic [31:0] IO_MASK = 32'h0000ff1d;
  localparam logic [31:0] CFG_MASK = 32'h80333300;
  localparam logic [31:0] RESET_VAL = 32'h00000000;
  // status bits: 0..4 wake per channel, 5 retention release
  localparam int NIRQ = 6;
  localparam int IRQ_RET = 5;
  typedef enum logic [1:0] {
    SMBC_LINK_NONE = 2'h0,
    SMBC_LINK_DIODE_BACKUP_TO_PRIMARY = 2'h1,
    SMBC_LINK_DIODE_PRIMARY_TO_BACKUP = 2'h2,
    SMBC_LINK_DIRECT = 2'h3
  } smbc_link_t;
  typedef enum logic [1:0] {
    SMBC_VOUT_SWITCH_OPEN = 2'h0,
    SMBC_VOUT_SWITCH_WEAK = 2'h1,
    SMBC_VOUT_SWITCH_MEDIUM = 2'h2,
    SMBC_VOUT_SWITCH_STRONG = 2'h3
  } smbc_vout_t;
  typedef struct packed {
    logic enable;
    logic [3:0] threshold_coarse_trim;
    logic [3:0] threshold_fine_trim;
  } smbc_chan_t;
  typedef struct packed {
    logic main_backup_comparator_off;
    smbc_link_t rail_link_normal_mode;
    smbc_link_t rail_link_backup_mode;
    logic [1:0] series_resistor_select;
    smbc_vout_t backup_output_resistor_select;
  } smbc_cfg_t;
endpackage

// ==== smbc_edge.sv ====
// module: per-channel monitor synchroniser and wake edge detector
`timescale 1ns/100ps
module smbc_edge
  import smbc_pkg::*;
(
  input wire logic mclk, // always-on clock
  input wire logic reset, // extended system reset
  input wire logic level_in, // raw comparator level
  input wire logic enable, // channel monitor enable
  output logic level, // synchronised level
  output logic rose, // one-cycle rising pulse
  output logic fell // one-cycle falling pulse
);
  logic meta;
  logic sync;
  logic prev;
  // [R13] two-stage synchroniser
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= level_in;
      sync <= meta;
    end
  end
  // history tracks the pin even while disabled, so enabling cannot fake an edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      prev <= 1'b0;
    end else begin
      prev <= sync;
    end
  end
  assign level = sync;
  // [R13] edges gated by enable
  assign rose = enable & sync & ~prev;
  assign fell = enable & ~sync & prev;
endmodule

// ==== smbc_top.sv ====
// module: supply monitor control and backup power configuration registers
// Function
// [R1] falling monitor edge wakes when drop set
// [R2] rising monitor edge wakes when climb set
// [R3] bit 0 enables each channel monitor
// [R4] coarse 15:12, fine 11:8 thresholds
// [R5] fields reset only on extended reset
// [R6] io retention released below threshold
// [R7] software sets comparator off without battery
// [R8] rail link fields per mode, four codes
// [R9] series resistor step in bits 13:12
// [R10] backup output resistor in bits 9:8
// [R11] output switch open, weak, medium, strong
// [R12] software writes zero to reserved bits
// [R13] monitor levels synchronised, edges detected
// [R14] single cycle access, reserved reads zero
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module smbc_top
  import smbc_pkg::*;
(
  input wire logic mclk, // 200 MHz always-on clock
  input wire logic reset, // extended system reset, active high
  input wire logic [ADDR_W-1:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic [NCH-1:0] monitor_level, // raw monitor outputs
  input wire logic hibernate_state, // device is in hibernate
  output logic [NCH-1:0] monitor_enable, // per channel enables
  output logic [NCH*8-1:0] monitor_threshold, // coarse:fine per channel
  output logic hibernate_wake, // wake pulse from hibernate
  output logic io_retention_release, // release pad retention
  output smbc_cfg_t backup_cfg, // backup switch configuration
  output logic irq // level interrupt
);
  logic [31:0] chreg [NCH];
  logic [31:0] cfgreg;
  logic [NIRQ-1:0] irq_status;
  logic [NIRQ-1:0] irq_mask;
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] rose;
  logic [NCH-1:0] fell;
  logic [NCH-1:0] wake_ev;
  logic ret_ev;
  logic [NIRQ-1:0] ev;

  function automatic int ch_index(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_ANA: ch_index = CH_ANA;
      OFF_ALT: ch_index = CH_ALT;
      OFF_DIG: ch_index = CH_DIG;
      OFF_IO: ch_index = CH_IO;
      OFF_BKP: ch_index = CH_BKP;
      default: ch_index = -1;
    endcase
  endfunction

  function automatic logic [31:0] ch_mask(input int idx);
    ch_mask = (idx == CH_IO) ? IO_MASK : CH_MASK;
  endfunction

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gch
      smbc_edge u_edge (
        .mclk(mclk),
        .reset(reset),
        .level_in(monitor_level[g]),
        .enable(chreg[g][BIT_EN]),
        .level(lvl[g]),
        .rose(rose[g]),
        .fell(fell[g])
      );
      // [R1] [R2] wake edge select
      assign wake_ev[g] = (rose[g] & chreg[g][BIT_CLIMB]) |
                          (fell[g] & chreg[g][BIT_DROP]);
      // [R5] channel fields on extended reset only
      always_ff @(posedge mclk) begin
        if (reset) begin
          chreg[g] <= RESET_VAL;
        end else if (wr && ch_index(addr) == g) begin
          // [R4] [R12] only defined fields stored
          chreg[g] <= wdata & ch_mask(g);
        end
      end
      // [R3] [R4] drive monitor controls
      always_ff @(posedge mclk) begin
        if (reset) begin
          monitor_enable[g] <= 1'b0;
          monitor_threshold[g*8 +: 8] <= 8'h00;
        end else begin
          monitor_enable[g] <= chreg[g][BIT_EN];
          monitor_threshold[g*8 +: 8] <= {chreg[g][COARSE_LO +: 4],
                                          chreg[g][FINE_LO +: 4]};
        end
      end
    end
  endgenerate

  // [R6] below threshold while enabled releases retention
  assign ret_ev = chreg[CH_IO][BIT_RETREL] & chreg[CH_IO][BIT_EN] &
                  fell[CH_IO];
  assign ev = {ret_ev, wake_ev};

  // [R7] [R8] [R9] [R10] config register, reserved bits dropped
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfgreg <= RESET_VAL;
    end else if (wr && addr == OFF_CFG) begin
      cfgreg <= wdata & CFG_MASK;
    end
  end

  // [R8] [R10] [R11] decoded config outputs
  always_ff @(posedge mclk) begin
    if (reset) begin
      backup_cfg <= '0;
    end else begin
      backup_cfg.main_backup_comparator_off <= cfgreg[BIT_CMPOFF];
      backup_cfg.rail_link_normal_mode <=
        smbc_link_t'(cfgreg[NORM_LO +: 2]);
      backup_cfg.rail_link_backup_mode <=
        smbc_link_t'(cfgreg[BKMODE_LO +: 2]);
      backup_cfg.series_resistor_select <= cfgreg[SER_LO +: 2];
      backup_cfg.backup_output_resistor_select <=
        smbc_vout_t'(cfgreg[VOUT_LO +: 2]);
    end
  end

  // [R1] [R2] wake asserted only while hibernating
  always_ff @(posedge mclk) begin
    if (reset) begin
      hibernate_wake <= 1'b0;
    end else begin
      hibernate_wake <= hibernate_state & (|wake_ev);
    end
  end

  // [R6] retention release holds until level recovers, hibernate ends or the io release bit is cleared
  always_ff @(posedge mclk) begin
    if (reset) begin
      io_retention_release <= 1'b0;
    end else if (ret_ev) begin
      io_retention_release <= 1'b1;
    end else if (!hibernate_state || !chreg[CH_IO][BIT_RETREL] ||
                 lvl[CH_IO]) begin
      io_retention_release <= 1'b0;
    end
  end

  // sticky status, write one clears; a new event beats the clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_status <= '0;
    end else if (wr && addr == OFF_IRQ_STATUS) begin
      irq_status <= (irq_status & ~wdata[NIRQ-1:0]) | ev;
    end else begin
      irq_status <= irq_status | ev;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_mask <= '0;
    end else if (wr && addr == OFF_IRQ_MASK) begin
      irq_mask <= wdata[NIRQ-1:0];
    end
  end

  // registered one cycle behind status, as all outputs are flops
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // [R14] single cycle read, reserved and unmapped read zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        OFF_ANA: rdata <= chreg[CH_ANA];
        OFF_ALT: rdata <= chreg[CH_ALT];
        OFF_DIG: rdata <= chreg[CH_DIG];
        OFF_IO: rdata <= chreg[CH_IO];
        OFF_BKP: rdata <= chreg[CH_BKP];
        OFF_CFG: rdata <= cfgreg;
        OFF_IRQ_STATUS: rdata <= {{(32-NIRQ){1'b0}}, irq_status};
        OFF_IRQ_MASK: rdata <= {{(32-NIRQ){1'b0}}, irq_mask};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule

// ==== smbc_top_props.sv ====
// checker: port-level properties of the supply monitor bank
`timescale 1ns/100ps
module smbc_props
  import smbc_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic reset, // reset
  input wire logic [ADDR_W-1:0] addr, // address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [31:0] rdata, // read data
  input wire logic [NCH-1:0] monitor_level, // raw levels
  input wire logic hibernate_state, // hibernate
  input wire logic [NCH-1:0] monitor_enable, // enables
  input wire logic [NCH*8-1:0] monitor_threshold, // thresholds
  input wire logic hibernate_wake, // wake pulse
  input wire logic io_retention_release, // retention release
  input wire smbc_cfg_t backup_cfg, // backup config
  input wire logic irq // interrupt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_dig_wr;
    wr && addr == OFF_DIG;
  endsequence
  sequence s_quiet;
    $stable(monitor_level) [*6];
  endsequence
  property p_cfg;
    logic [31:0] d;
    (wr && addr == OFF_CFG, d = wdata) |-> ##2
      backup_cfg == {d[31], d[21:20], d[17:16], d[13:12], d[9:8]};
  endproperty
  a_read_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
  a_en_write: assert property (s_dig_wr |-> ##2
    monitor_enable[CH_DIG] == $past(wdata[BIT_EN], 2))
    else $error("enable does not follow write");
  a_thr_write: assert property (s_dig_wr |-> ##2
    monitor_threshold[8*CH_DIG +: 8] == $past(wdata[15:8], 2))
    else $error("threshold does not follow write");
  a_cfg_write: assert property (p_cfg)
    else $error("backup config does not follow write");
  a_wake_hib: assert property (hibernate_wake |-> $past(hibernate_state))
    else $error("wake outside hibernate");
  a_wake_single: assert property (hibernate_wake |=> !hibernate_wake)
    else $error("wake pulse too long");
  a_quiet_nowake: assert property (s_quiet |=> !hibernate_wake)
    else $error("wake without monitor edge");
  a_ret_cause: assert property ($rose(io_retention_release) |->
    $past(monitor_enable[CH_IO]) && !$past(monitor_level[CH_IO], 2))
    else $error("retention released without io drop");
endmodule
bind smbc_top smbc_props smbc_props_inst (.mclk, .reset, .addr, .wdata,
  .wr, .rd, .rdata, .monitor_level, .hibernate_state, .monitor_enable,
  .monitor_threshold, .hibernate_wake, .io_retention_release, .backup_cfg,
  .irq);

// ==== smbc_top_tb.sv ====
// testbench: register, wake and retention checks of the supply monitor bank
`timescale 1ns/100ps
module smbc_top_tb;
  import smbc_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [NCH-1:0] monitor_level = 5'h00;
  logic hibernate_state = 1'b0;
  logic [31:0] rdata;
  logic [NCH-1:0] monitor_enable;
  logic [NCH*8-1:0] monitor_threshold;
  logic hibernate_wake, io_retention_release, irq, seen;
  logic [1:0] c;
  smbc_cfg_t backup_cfg;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] offs [6] = '{OFF_ANA, OFF_ALT, OFF_DIG, OFF_IO, OFF_BKP,
    OFF_CFG};
  logic [31:0] msks [6] = '{CH_MASK, CH_MASK, CH_MASK, IO_MASK, CH_MASK,
    CFG_MASK};
  smbc_top smbc_top_inst (.mclk, .reset, .addr, .wdata, .wr, .rd, .rdata,
    .monitor_level, .hibernate_state, .monitor_enable, .monitor_threshold,
    .hibernate_wake, .io_retention_release, .backup_cfg, .irq);
  always #2.5 mclk = ~mclk;
  // whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (hibernate_wake === 1'b1) seen = 1'b1;
    if (cycles > 3000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // move one monitor pin, then see whether a wake pulse came out
  task automatic pin(input int ch, input logic lvl, input logic exp);
    @(posedge mclk);
    seen = 1'b0;
    monitor_level[ch] <= lvl;
    repeat (8) @(posedge mclk);
    #1 chk(seen, exp);
  endtask
  task automatic do_reset();
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    do_reset();
    foreach (offs[i]) rchk(offs[i], 32'h0);
    foreach (offs[i]) begin
      wreg(offs[i], 32'hffffffff);
      rchk(offs[i], msks[i]);
    end
    chk(monitor_enable, 32'h1f);
    chk(monitor_threshold[31:0], 32'hffffffff);
    chk(monitor_threshold[39:32], 32'hff);
    chk(backup_cfg, 32'h1ff);
    wreg(8'hb0, 32'hffffffff);
    rchk(8'hb0, 32'h0);
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      wreg(OFF_CFG, {10'h0, c, 2'h0, c, 2'h0, c, 2'h0, c, 8'h0});
      @(posedge mclk);
      #1 chk(backup_cfg, {1'b0, c, c, c, c});
    end
    do_reset();
    rchk(OFF_IO, 32'h0);
    rchk(OFF_CFG, 32'h0);
    $display("test registers done");
    @(posedge mclk) hibernate_state <= 1'b1;
    foreach (offs[i]) if (i < NCH) begin
      wreg(offs[i], 32'hd);
      pin(i, 1'b1, 1'b1);
      pin(i, 1'b0, 1'b1);
    end
    rchk(OFF_IRQ_STATUS, 32'h1f);
    chk(irq, 1'b0); // masked off
    wreg(OFF_IRQ_MASK, 32'h3f);
    repeat (2) @(posedge mclk);
    #1 chk(irq, 1'b1);
    wreg(OFF_IRQ_STATUS, 32'h3f);
    rchk(OFF_IRQ_STATUS, 32'h0);
    chk(irq, 1'b0);
    wreg(OFF_DIG, 32'h5);
    pin(CH_DIG, 1'b1, 1'b1);
    pin(CH_DIG, 1'b0, 1'b0);
    wreg(OFF_DIG, 32'h9);
    pin(CH_DIG, 1'b1, 1'b0);
    pin(CH_DIG, 1'b0, 1'b1);
    wreg(OFF_DIG, 32'hc);
    pin(CH_DIG, 1'b1, 1'b0);
    wreg(OFF_DIG, 32'hd);
    @(posedge mclk) hibernate_state <= 1'b0;
    pin(CH_DIG, 1'b0, 1'b0);
    $display("test wake done");
    @(posedge mclk) hibernate_state <= 1'b1;
    wreg(OFF_IO, 32'h11);
    pin(CH_IO, 1'b1, 1'b0);
    chk(io_retention_release, 1'b0);
    wreg(OFF_IRQ_STATUS, 32'h3f);
    pin(CH_IO, 1'b0, 1'b0);
    chk(io_retention_release, 1'b1);
    rchk(OFF_IRQ_STATUS, 32'h20);
    @(posedge mclk) hibernate_state <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(io_retention_release, 1'b0);
    $display("test retention done");
    finish_test();
  end
endmodule
